// ==== hw/nio_pkg.sv ====
// Shared constants and command codes for the nibble I/O port block.
// Assumes one system clock; all pin inputs are synchronous to it.
package nio_pkg;

   localparam int NIO_W = 4;

   // Port output configuration fields
   localparam int NIO_CFG_OD_A = 0;
   localparam int NIO_CFG_OD_B = 1;
   localparam int NIO_CFG_PULLUP = 2;

   // Bit of the 8-bit hold and interrupt masks that belongs to the input group
   localparam int NIO_EVT_BIT = 2;

   // Reset values
   localparam logic [3:0] NIO_CFG_RST = 4'h0;
   localparam logic [3:0] NIO_DIR_RST = 4'hf;
   localparam logic [3:0] NIO_OUT_RST = 4'hf;
   localparam logic [3:0] NIO_LATCH_RST = 4'hf;
   localparam logic [3:0] NIO_MASK_RST = 4'h0;
   localparam logic [3:0] NIO_STAT_RST = 4'h0;

   // Port and mode instructions
   typedef enum logic [4:0] {
      NIO_NOP      = 5'h00,
      NIO_WR_CFG   = 5'h01,
      NIO_WR_DIR_A = 5'h02,
      NIO_WR_DIR_B = 5'h03,
      NIO_WR_DIR_D = 5'h04,
      NIO_WR_CHG   = 5'h05,
      NIO_WR_HOLD  = 5'h06,
      NIO_WR_IRQ   = 5'h07,
      NIO_WR_STOP  = 5'h08,
      NIO_WR_A     = 5'h09,
      NIO_WR_B     = 5'h0a,
      NIO_WR_D     = 5'h0b,
      NIO_WR_LED   = 5'h0c,
      NIO_WR_PLAIN = 5'h0d,
      NIO_RD_A     = 5'h0e,
      NIO_RD_B     = 5'h0f,
      NIO_RD_D     = 5'h10,
      NIO_RD_STAT  = 5'h11,
      NIO_CLR_STAT = 5'h12,
      NIO_CLR_EVT  = 5'h13
   } nio_cmd_t;

endpackage

// ==== hw/nio_pin_drive.sv ====
// Registered pin driver for one 4-bit bidirectional group.
// Assumes the pad resolves the wire from out and oe_n; oe_n low means driving.
`timescale 1ns/100ps
module nio_pin_drive #(
   parameter int W = 4,
   parameter bit HAS_OD = 1'b1
) (
   input wire logic mclk, // System clock
   input wire logic arst_n, // Asynchronous reset, active low
   input wire logic [W-1:0] dir, // 0 output, 1 input
   input wire logic [W-1:0] data, // Output latch
   input wire logic od, // Open-drain select
   output logic [W-1:0] pin_out, // Pad output level
   output logic [W-1:0] pin_oe_n // Pad enable, low drives
);
   wire logic use_od;
   wire logic [W-1:0] next_out;
   wire logic [W-1:0] next_oe_n;

   // Open drain only pulls low; a high bit floats the pad
   assign use_od = HAS_OD & od;
   assign next_out = use_od ? '0 : data;
   assign next_oe_n = dir | (use_od ? data : '0);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out <= '0;
         pin_oe_n <= '1;
      end else begin
         pin_out <= next_out;
         pin_oe_n <= next_oe_n;
      end
   end
endmodule

// ==== hw/nio_change_det.sv ====
// Synchroniser and change/falling-edge detector for the input-only group.
// Assumes pins are slow against the system clock.
`timescale 1ns/100ps
module nio_change_det #(
   parameter int W = 4
) (
   input wire logic mclk, // System clock
   input wire logic arst_n, // Asynchronous reset, active low
   input wire logic [W-1:0] pins, // Raw input pins
   output logic [W-1:0] level, // Synchronised level
   output logic [W-1:0] chg, // Any change this cycle
   output logic [W-1:0] fall // Falling edge this cycle
);
   logic [W-1:0] meta;
   logic [W-1:0] prev;
   logic [2:0] primed;

   // Compare two synchronised samples only once both are real
   assign chg = primed[2] ? (level ^ prev) : '0;
   assign fall = primed[2] ? (prev & ~level) : '0;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= '0;
         level <= '0;
         prev <= '0;
         primed <= 3'h0;
      end else begin
         meta <= pins;
         level <= meta;
         prev <= level;
         primed <= {primed[1:0], 1'b1};
      end
   end
endmodule

// ==== hw/nio_ports.sv ====
// Parallel nibble I/O ports: three bidirectional groups, one input group
// with change status and wake logic, and two output-only groups.
// Assumes one instruction per cycle on the command port; pins are synchronous.
//
// What this block does
// [RULE_01] Config bit 0: group A open drain
// [RULE_02] Config bit 1: group B open drain
// [RULE_03] Config bit 2 enables input pull-ups
// [RULE_04] Group D always push-pull when output
// [RULE_05] Group A direction: 0 output, reset ones
// [RULE_06] Group B direction: 0 output, reset ones
// [RULE_07] Group D direction: 0 output, reset ones
// [RULE_08] All bidirectional pins are inputs after reset
// [RULE_09] Read returns pins; write loads output latch
// [RULE_10] Input pin change sets its status bit
// [RULE_11] Status read-only, cleared by clear instruction
// [RULE_12] Change wakes or interrupts only when masks set
// [RULE_13] Masked falling edge exits stop mode
// [RULE_14] LED write drives high-sink pins
// [RULE_15] Plain output write drives its pins
// [RULE_16] Pull-ups disabled after reset
// [RULE_17] Groups A, B push-pull after reset
// [RULE_18] Per-pin change mask gates wake and interrupt
// [RULE_19] Inputs synchronised, change by sample compare
// [RULE_20] New change wins over same-cycle clear
`timescale 1ns/100ps
module nio_ports
   import nio_pkg::*;
(
   input wire logic mclk, // System clock, 250 MHz
   input wire logic arst_n, // Asynchronous reset, active low
   input wire logic cmd_valid, // Instruction strobe
   input wire nio_pkg::nio_cmd_t cmd_op, // Instruction code
   input wire logic [7:0] cmd_data, // Immediate or register operand
   input wire logic irq_ack, // Interrupt accepted, clears event
   output logic rd_valid, // Read data valid
   output logic [3:0] rd_data, // Read data
   input wire logic [3:0] pin_a_in, // Group A pad level
   output logic [3:0] pin_a_out, // Group A pad output
   output logic [3:0] pin_a_oe_n, // Group A pad enable, low drives
   input wire logic [3:0] pin_b_in, // Group B pad level
   output logic [3:0] pin_b_out, // Group B pad output
   output logic [3:0] pin_b_oe_n, // Group B pad enable, low drives
   input wire logic [3:0] pin_d_in, // Group D pad level
   output logic [3:0] pin_d_out, // Group D pad output
   output logic [3:0] pin_d_oe_n, // Group D pad enable, low drives
   input wire logic [3:0] pin_c_in, // Input-only group pads
   output logic pullup_en, // Input group pull-up enable
   output logic [3:0] led_sink_out, // High-sink LED pins
   output logic [3:0] plain_out_group, // Output-only pins
   output logic hold_release, // Hold release request
   output logic irq_req, // Interrupt request
   output logic stop_wake // Stop-mode exit pulse
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   logic [3:0] port_output_config;
   logic [3:0] group_a_direction;
   logic [3:0] group_b_direction;
   logic [3:0] group_d_direction;
   logic [3:0] latch_a;
   logic [3:0] latch_b;
   logic [3:0] latch_d;
   logic [3:0] change_detect_mask;
   logic hold_wake_mask;
   logic irq_mask;
   logic [3:0] stop_wake_mask;
   logic [3:0] change_status;
   logic rc_event;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode

   wire logic wr_cfg;
   wire logic wr_dir_a;
   wire logic wr_dir_b;
   wire logic wr_dir_d;
   wire logic wr_chg;
   wire logic wr_hold;
   wire logic wr_irq;
   wire logic wr_stop;
   wire logic wr_a;
   wire logic wr_b;
   wire logic wr_d;
   wire logic wr_led;
   wire logic wr_plain;
   wire logic rd_any;
   wire logic clr_stat;
   wire logic clr_evt;
   wire logic [3:0] nib;

   assign nib = cmd_data[3:0];
   assign wr_cfg = cmd_valid && (cmd_op == NIO_WR_CFG);
   assign wr_dir_a = cmd_valid && (cmd_op == NIO_WR_DIR_A);
   assign wr_dir_b = cmd_valid && (cmd_op == NIO_WR_DIR_B);
   assign wr_dir_d = cmd_valid && (cmd_op == NIO_WR_DIR_D);
   assign wr_chg = cmd_valid && (cmd_op == NIO_WR_CHG);
   assign wr_hold = cmd_valid && (cmd_op == NIO_WR_HOLD);
   assign wr_irq = cmd_valid && (cmd_op == NIO_WR_IRQ);
   assign wr_stop = cmd_valid && (cmd_op == NIO_WR_STOP);
   assign wr_a = cmd_valid && (cmd_op == NIO_WR_A);
   assign wr_b = cmd_valid && (cmd_op == NIO_WR_B);
   assign wr_d = cmd_valid && (cmd_op == NIO_WR_D);
   assign wr_led = cmd_valid && (cmd_op == NIO_WR_LED);
   assign wr_plain = cmd_valid && (cmd_op == NIO_WR_PLAIN);
   assign clr_stat = cmd_valid && (cmd_op == NIO_CLR_STAT);
   assign clr_evt = (cmd_valid && (cmd_op == NIO_CLR_EVT)) || irq_ack;
   assign rd_any = cmd_valid && ((cmd_op == NIO_RD_A) || (cmd_op == NIO_RD_B) ||
                                 (cmd_op == NIO_RD_D) || (cmd_op == NIO_RD_STAT));

   ////////////////////////////////////////////////////////////////////////////
   // Mode and direction registers

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         port_output_config <= NIO_CFG_RST; // see [RULE_16] see [RULE_17]
         group_a_direction <= NIO_DIR_RST; // see [RULE_05] see [RULE_08]
         group_b_direction <= NIO_DIR_RST; // see [RULE_06] see [RULE_08]
         group_d_direction <= NIO_DIR_RST; // see [RULE_07] see [RULE_08]
         change_detect_mask <= NIO_MASK_RST;
         hold_wake_mask <= 1'b0;
         irq_mask <= 1'b0;
         stop_wake_mask <= NIO_MASK_RST;
      end else begin
         if (wr_cfg) begin
            port_output_config <= {1'b0, nib[2:0]}; // see [RULE_03]
         end
         if (wr_dir_a) begin
            group_a_direction <= nib; // see [RULE_05]
         end
         if (wr_dir_b) begin
            group_b_direction <= nib; // see [RULE_06]
         end
         if (wr_dir_d) begin
            group_d_direction <= nib; // see [RULE_07]
         end
         if (wr_chg) begin
            change_detect_mask <= nib; // see [RULE_18]
         end
         if (wr_hold) begin
            hold_wake_mask <= cmd_data[NIO_EVT_BIT];
         end
         if (wr_irq) begin
            irq_mask <= cmd_data[NIO_EVT_BIT];
         end
         if (wr_stop) begin
            stop_wake_mask <= nib;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output latches and output-only groups

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         latch_a <= NIO_LATCH_RST;
         latch_b <= NIO_LATCH_RST;
         latch_d <= NIO_LATCH_RST;
         led_sink_out <= NIO_OUT_RST;
         plain_out_group <= NIO_OUT_RST;
      end else begin
         if (wr_a) begin
            latch_a <= nib; // see [RULE_09]
         end
         if (wr_b) begin
            latch_b <= nib; // see [RULE_09]
         end
         if (wr_d) begin
            latch_d <= nib; // see [RULE_09]
         end
         if (wr_led) begin
            led_sink_out <= nib; // see [RULE_14]
         end
         if (wr_plain) begin
            plain_out_group <= nib; // see [RULE_15]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bidirectional pin drivers

   nio_pin_drive #(.W(NIO_W), .HAS_OD(1'b1)) u_drive_a (
      .mclk(mclk),
      .arst_n(arst_n),
      .dir(group_a_direction),
      .data(latch_a),
      .od(port_output_config[NIO_CFG_OD_A]), // see [RULE_01]
      .pin_out(pin_a_out),
      .pin_oe_n(pin_a_oe_n)
   );

   nio_pin_drive #(.W(NIO_W), .HAS_OD(1'b1)) u_drive_b (
      .mclk(mclk),
      .arst_n(arst_n),
      .dir(group_b_direction),
      .data(latch_b),
      .od(port_output_config[NIO_CFG_OD_B]), // see [RULE_02]
      .pin_out(pin_b_out),
      .pin_oe_n(pin_b_oe_n)
   );

   // Group D has no open-drain option
   nio_pin_drive #(.W(NIO_W), .HAS_OD(1'b0)) u_drive_d (
      .mclk(mclk),
      .arst_n(arst_n),
      .dir(group_d_direction),
      .data(latch_d),
      .od(1'b0), // see [RULE_04]
      .pin_out(pin_d_out),
      .pin_oe_n(pin_d_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Input group: change status, event and wake

   wire logic [3:0] c_level;
   wire logic [3:0] c_chg;
   wire logic [3:0] c_fall;
   wire logic evt_set;
   wire logic next_hold;
   wire logic next_irq;
   wire logic next_stop;

   nio_change_det #(.W(NIO_W)) u_det_c (
      .mclk(mclk),
      .arst_n(arst_n),
      .pins(pin_c_in), // see [RULE_19]
      .level(c_level),
      .chg(c_chg),
      .fall(c_fall)
   );

   assign evt_set = |(c_chg & change_detect_mask); // see [RULE_18]
   assign next_hold = rc_event && hold_wake_mask; // see [RULE_12]
   assign next_irq = rc_event && irq_mask; // see [RULE_12]
   assign next_stop = |(c_fall & stop_wake_mask); // see [RULE_13]

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         change_status <= NIO_STAT_RST;
         rc_event <= 1'b0;
         hold_release <= 1'b0;
         irq_req <= 1'b0;
         stop_wake <= 1'b0;
         pullup_en <= 1'b0;
      end else begin
         // A change in the clearing cycle survives the clear
         change_status <= (clr_stat ? '0 : change_status) | c_chg; // see [RULE_10] see [RULE_20]
         rc_event <= (rc_event && !clr_evt) || evt_set; // see [RULE_20]
         hold_release <= next_hold;
         irq_req <= next_irq;
         stop_wake <= next_stop;
         pullup_en <= port_output_config[NIO_CFG_PULLUP]; // see [RULE_03]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   logic [3:0] next_rd;

   always_comb begin
      next_rd = 4'h0;
      unique case (cmd_op)
         NIO_RD_A: next_rd = pin_a_in; // see [RULE_09]
         NIO_RD_B: next_rd = pin_b_in; // see [RULE_09]
         NIO_RD_D: next_rd = pin_d_in; // see [RULE_09]
         NIO_RD_STAT: next_rd = change_status; // see [RULE_11]
         default: next_rd = 4'h0;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_valid <= 1'b0;
         rd_data <= 4'h0;
      end else begin
         rd_valid <= rd_any;
         rd_data <= rd_any ? next_rd : 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   od_a_float_a: assert property ( // see [RULE_01]
      @(posedge mclk) disable iff (!arst_n)
      (port_output_config[0] && !group_a_direction[0] && latch_a[0])
      |=> (pin_a_oe_n[0] && !pin_a_out[0]))
      else $error("group A open drain drove a high");

   od_b_low_a: assert property ( // see [RULE_02]
      @(posedge mclk) disable iff (!arst_n)
      (port_output_config[1] && !group_b_direction[1] && !latch_b[1])
      |=> (!pin_b_oe_n[1] && !pin_b_out[1]))
      else $error("group B open drain did not pull low");

   pullup_follow_a: assert property ( // see [RULE_03]
      @(posedge mclk) disable iff (!arst_n)
      wr_cfg |=> ##1 (pullup_en == $past(cmd_data[2], 2)))
      else $error("pull-up enable does not follow config");

   d_push_pull_a: assert property ( // see [RULE_04]
      @(posedge mclk) disable iff (!arst_n)
      (group_d_direction == 4'h0) |=> (pin_d_oe_n == 4'h0 && pin_d_out == $past(latch_d)))
      else $error("group D not driving push-pull");

   dir_a_input_a: assert property ( // see [RULE_05]
      @(posedge mclk) disable iff (!arst_n)
      (wr_dir_a && nib == 4'hf) |=> ##1 (pin_a_oe_n == 4'hf))
      else $error("group A not released to input");

   dir_b_output_a: assert property ( // see [RULE_06]
      @(posedge mclk) disable iff (!arst_n)
      (wr_dir_b && nib == 4'h0 && !port_output_config[1]) |=> ##1 (pin_b_oe_n == 4'h0))
      else $error("group B not driving after direction write");

   stat_set_a: assert property ( // see [RULE_10]
      @(posedge mclk) disable iff (!arst_n)
      c_chg[0] |=> change_status[0] ##1 (change_status[0] || $past(clr_stat)))
      else $error("change status bit 0 not set by change");

   stat_clear_a: assert property ( // see [RULE_11]
      @(posedge mclk) disable iff (!arst_n)
      (clr_stat && c_chg == 4'h0) |=> (change_status == 4'h0))
      else $error("change status not cleared");

   set_wins_a: assert property ( // see [RULE_20]
      @(posedge mclk) disable iff (!arst_n)
      (clr_stat && c_chg != 4'h0) |=> ((change_status & $past(c_chg)) == $past(c_chg)))
      else $error("change lost to same-cycle clear");

   irq_gate_a: assert property ( // see [RULE_12]
      @(posedge mclk) disable iff (!arst_n)
      (evt_set && irq_mask && !wr_irq) |=> ##1 irq_req)
      else $error("masked change gave no interrupt");

   mask_block_a: assert property ( // see [RULE_18]
      @(posedge mclk) disable iff (!arst_n)
      (c_chg != 4'h0 && (c_chg & change_detect_mask) == 4'h0 && !rc_event) |=> !rc_event)
      else $error("event raised with change mask clear");

   stop_wake_a: assert property ( // see [RULE_13]
      @(posedge mclk) disable iff (!arst_n)
      $fell(c_level[3]) && stop_wake_mask[3] |=> stop_wake)
      else $error("falling edge did not wake from stop");

   led_write_a: assert property ( // see [RULE_14]
      @(posedge mclk) disable iff (!arst_n)
      wr_led |=> (led_sink_out == $past(nib)))
      else $error("LED pins do not show written nibble");

   plain_write_a: assert property ( // see [RULE_15]
      @(posedge mclk) disable iff (!arst_n)
      wr_plain |=> (plain_out_group == $past(nib)))
      else $error("output group does not show written nibble");

   read_pins_a: assert property ( // see [RULE_09]
      @(posedge mclk) disable iff (!arst_n)
      (cmd_valid && cmd_op == NIO_RD_A) |=> (rd_valid && rd_data == $past(pin_a_in)))
      else $error("group A read does not return pins");

endmodule

// ==== verif/nio_pin_model.sv ====
// Pad model for the nibble ports: resolves each bidirectional pad from the
// block's drive and an external source. Assumes oe_n low means driving.
`timescale 1ns/100ps
module nio_pin_model (
   input wire logic mclk, // System clock
   input wire logic [2:0][3:0] dout, // Block pad outputs, groups A B D
   input wire logic [2:0][3:0] doe_n, // Block pad enables, low drives
   input wire logic [2:0][3:0] ext_val, // External source level
   input wire logic [2:0][3:0] ext_en, // External source present
   output logic [2:0][3:0] din, // Resolved pad levels
   input wire logic pullup_en, // Input group pull-ups on
   input wire logic [3:0] c_val, // Switch levels on input group
   input wire logic c_en, // Switches connected
   output logic [3:0] c_in // Resolved input group levels
);
   logic flip = 1'b0;

   // A floating pad wanders, so its level changes every cycle
   always @(posedge mclk) begin
      flip <= ~flip;
   end

   always_comb begin
      for (int g = 0; g < 3; g++) begin
         for (int i = 0; i < 4; i++) begin
            din[g][i] = !doe_n[g][i] ? dout[g][i] : ext_en[g][i] ? ext_val[g][i] : flip;
         end
      end
   end

   assign c_in = c_en ? c_val : (pullup_en ? 4'hf : {4{flip}});
endmodule

// ==== verif/nio_ports_tb.sv ====
// Self-checking bench for the nibble I/O port block.
// Assumes the pad model above stands on the far side of every bidirectional and input-group pin.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module nio_ports_tb;
   import nio_pkg::*;
   logic mclk, arst_n, cmd_valid, irq_ack, rd_valid, pullup_en;
   logic hold_release, irq_req, stop_wake, c_en;
   nio_cmd_t cmd_op;
   logic [7:0] cmd_data;
   logic [3:0] rd_data, pin_c_in, led_sink_out, plain_out_group, c_val;
   logic [3:0] pin_a_out, pin_b_out, pin_d_out, pin_a_oe_n, pin_b_oe_n, pin_d_oe_n;
   logic [2:0][3:0] dout, doe, ext_val, ext_en, din;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;

   assign dout = {pin_d_out, pin_b_out, pin_a_out};
   assign doe = {pin_d_oe_n, pin_b_oe_n, pin_a_oe_n};

   nio_ports dut_u (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_data(cmd_data), .irq_ack(irq_ack), .rd_valid(rd_valid), .rd_data(rd_data),
      .pin_a_in(din[0]), .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n),
      .pin_b_in(din[1]), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n),
      .pin_d_in(din[2]), .pin_d_out(pin_d_out), .pin_d_oe_n(pin_d_oe_n),
      .pin_c_in(pin_c_in), .pullup_en(pullup_en), .led_sink_out(led_sink_out),
      .plain_out_group(plain_out_group), .hold_release(hold_release), .irq_req(irq_req),
      .stop_wake(stop_wake));

   nio_pin_model pads_u (.mclk(mclk), .dout(dout), .doe_n(doe), .ext_val(ext_val),
      .ext_en(ext_en), .din(din), .pullup_en(pullup_en), .c_val(c_val), .c_en(c_en),
      .c_in(pin_c_in));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task results;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         results();
      end
   end

   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // One instruction; returns at the edge that takes it
   task cmd(input nio_cmd_t op, input logic [7:0] d);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_data <= d;
      @(posedge mclk);
      cmd_valid <= 1'b0;
   endtask

   task rd(input nio_cmd_t op, input logic [3:0] exp);
      cmd(op, 8'h00);
      #1;
      `CHK("rd_valid", 1'b1, rd_valid);
      `CHK("rd_data", exp, rd_data);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      `CHK("oe_n_reset", 12'hfff, doe);
      `CHK("pullup_reset", 1'b0, pullup_en);
      `CHK("led_reset", 4'hf, led_sink_out);
      `CHK("plain_reset", 4'hf, plain_out_group);
   endtask

   task t_bidir(input int g, input logic [3:0] od);
      nio_cmd_t wl, wd, rop;
      wl = g == 0 ? NIO_WR_A : g == 1 ? NIO_WR_B : NIO_WR_D;
      wd = g == 0 ? NIO_WR_DIR_A : g == 1 ? NIO_WR_DIR_B : NIO_WR_DIR_D;
      rop = g == 0 ? NIO_RD_A : g == 1 ? NIO_RD_B : NIO_RD_D;
      ext_val[g] <= 4'hf;
      ext_en[g] <= 4'hf;
      cmd(wl, 8'h05);
      cmd(wd, 8'h00);
      tick(1);
      `CHK("oe_n_pp", 4'h0, doe[g]);
      `CHK("out_pp", 4'h5, dout[g]);
      rd(rop, 4'h5);
      cmd(NIO_WR_CFG, {4'h0, od});
      tick(1);
      `CHK("oe_n_od", g == 2 ? 4'h0 : 4'h5, doe[g]);
      // Driven high bits exist only where the group stays push-pull
      `CHK("out_od", g == 2 ? 4'h5 : 4'h0, dout[g] & ~doe[g]);
      rd(rop, 4'h5);
      cmd(NIO_WR_CFG, 8'h00);
      ext_val[g] <= 4'ha;
      cmd(wd, 8'h0c);
      tick(1);
      `CHK("oe_n_mixed", 4'hc, doe[g]);
      rd(rop, 4'h9);
      cmd(wd, 8'h0f);
      tick(1);
      `CHK("oe_n_input", 4'hf, doe[g]);
      ext_en[g] <= 4'h0;
   endtask

   task t_outs;
      cmd(NIO_WR_LED, 8'h3a);
      cmd(NIO_WR_PLAIN, 8'hc6);
      tick(1);
      `CHK("led", 4'ha, led_sink_out);
      `CHK("plain", 4'h6, plain_out_group);
      cmd(NIO_WR_CFG, 8'h04);
      tick(1);
      `CHK("pullup_on", 1'b1, pullup_en);
      cmd(NIO_WR_CFG, 8'h00);
      tick(1);
      `CHK("pullup_off", 1'b0, pullup_en);
   endtask

   task t_change;
      cmd(NIO_WR_CHG, 8'h01);
      cmd(NIO_WR_HOLD, 8'h04);
      cmd(NIO_WR_IRQ, 8'h04);
      cmd(NIO_CLR_STAT, 8'h00);
      cmd(NIO_CLR_EVT, 8'h00);
      @(posedge mclk);
      c_val <= 4'h1;
      tick(6);
      `CHK("irq_set", 1'b1, irq_req);
      `CHK("hold_set", 1'b1, hold_release);
      rd(NIO_RD_STAT, 4'h1);
      @(posedge mclk);
      irq_ack <= 1'b1;
      @(posedge mclk);
      irq_ack <= 1'b0;
      tick(2);
      `CHK("irq_acked", 1'b0, irq_req);
      @(posedge mclk);
      c_val <= 4'h3;
      tick(6);
      `CHK("irq_unmasked_pin", 1'b0, irq_req);
      rd(NIO_RD_STAT, 4'h3);
      cmd(NIO_CLR_STAT, 8'h00);
      rd(NIO_RD_STAT, 4'h0);
      // Pin 0 change reaches the status bit at the edge that takes the clear
      @(posedge mclk);
      c_val <= 4'h2;
      @(posedge mclk);
      cmd(NIO_CLR_STAT, 8'h00);
      rd(NIO_RD_STAT, 4'h1);
      cmd(NIO_WR_HOLD, 8'h00);
      tick(2);
      `CHK("irq_again", 1'b1, irq_req);
      `CHK("hold_masked", 1'b0, hold_release);
      cmd(NIO_CLR_EVT, 8'h00);
      tick(2);
      `CHK("irq_cleared", 1'b0, irq_req);
   endtask

   task edge_cnt(input logic [3:0] v, input int exp);
      int cnt;
      cnt = 0;
      @(posedge mclk);
      c_val <= v;
      repeat (8) begin
         @(posedge mclk);
         #1;
         if (stop_wake === 1'b1) cnt++;
      end
      `CHK("stop_wake", exp, cnt);
   endtask

   task t_stop;
      cmd(NIO_WR_STOP, 8'h08);
      edge_cnt(4'ha, 0);
      edge_cnt(4'h8, 0);
      edge_cnt(4'h0, 1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_op <= NIO_NOP;
      cmd_data <= 8'h00;
      irq_ack <= 1'b0;
      ext_val <= '0;
      ext_en <= '0;
      c_val <= 4'h0;
      c_en <= 1'b1;
      tick(5);
      t_reset;
      @(posedge mclk);
      arst_n <= 1'b1;
      tick(4);
      t_bidir(0, 4'h1);
      t_bidir(1, 4'h2);
      t_bidir(2, 4'h3);
      t_outs;
      t_change;
      t_stop;
      results;
   end
endmodule
